// file: hw/fmd_pkg.sv
// Purpose: Shared constants for the freefall/motion detection unit
// Assumes: 50 MHz ref_clk, byte-wide register port from the serial host slave
// Notes:   Offsets, field positions, reset values and cycle counts live here
package fmd_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] ADDR_CFG      = 8'h15;
   localparam logic [7:0] ADDR_SRC      = 8'h16;
   localparam logic [7:0] ADDR_THS      = 8'h17;
   localparam logic [7:0] ADDR_CNT      = 8'h18;
   localparam logic [7:0] RST_CFG       = 8'h00;
   localparam logic [7:0] RST_THS       = 8'h00;
   localparam logic [7:0] RST_CNT       = 8'h00;
   localparam logic [5:0] RST_FLAGS     = 6'h00;
   localparam int         CFG_LATCH_BIT = 7;
   localparam int         CFG_OR_BIT    = 6;
   localparam int         CFG_Z_BIT     = 5;
   localparam int         CFG_Y_BIT     = 4;
   localparam int         CFG_X_BIT     = 3;
   localparam logic [7:0] CFG_WR_MASK   = 8'hF8;
   localparam int         THS_DBM_BIT   = 7;
   localparam int         MAG_SHIFT     = 6;
   localparam logic [6:0] LOW_NOISE_CAP = 7'h3F;
   ////////////////////////////////////////////////////////////////////////////
   // Debounce time step is a multiple of the 1.25 ms base step
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_BASE_NS  = 1250000;
   localparam int STEP_BASE_CYC = (STEP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] RATE_800 = 3'h0;
   localparam logic [2:0] RATE_400 = 3'h1;
   localparam logic [2:0] RATE_200 = 3'h2;
   localparam logic [2:0] RATE_100 = 3'h3;
   localparam logic [2:0] RATE_50  = 3'h4;
   localparam logic [2:0] RATE_12  = 3'h5;
   localparam logic [1:0] OSM_NORMAL = 2'h0;
   localparam logic [1:0] OSM_LOW_POWER_LOW_NOISE_MODE   = 2'h1;
   localparam logic [1:0] OSM_HIRES  = 2'h2;
   localparam logic [1:0] OSM_LP     = 2'h3;
   localparam logic [7:0] MULT_1  = 8'h01;
   localparam logic [7:0] MULT_2  = 8'h02;
   localparam logic [7:0] MULT_4  = 8'h04;
   localparam logic [7:0] MULT_8  = 8'h08;
   localparam logic [7:0] MULT_16 = 8'h10;
   localparam logic [7:0] MULT_64 = 8'h40;
   localparam logic [7:0] MULT_128 = 8'h80;
endpackage

// file: hw/fmd_debounce.sv
// Purpose: Debounce counter for the detection condition
// Assumes: tick marks one debounce time step, cond is stable between ticks
// Notes:   Counter never passes limit; hit and drop are combinational
`timescale 1ns/100ps
`default_nettype none
module fmd_debounce
(
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       tick,
   input  wire logic       cond,
   input  wire logic       clear_mode,
   input  wire logic       clear_now,
   input  wire logic [7:0] limit,
   output logic      [7:0] cnt_ff,
   output logic            hit,
   output logic            drop
);
   logic [7:0] nxt_cnt;
   logic [7:0] step_cnt;
   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      step_cnt = cnt_ff;
      if (cond)
      begin
         // Clamp also covers a limit lowered below the running count
         step_cnt = (cnt_ff >= limit) ? limit : cnt_ff + 8'h01;
      end
      else if (clear_mode)
      begin
         step_cnt = 8'h00;
      end
      else if (cnt_ff != 8'h00)
      begin
         step_cnt = cnt_ff - 8'h01;
      end
      nxt_cnt = cnt_ff;
      if (clear_now)
      begin
         nxt_cnt = 8'h00;
      end
      else if (tick)
      begin
         nxt_cnt = step_cnt;
      end
   end

   // Not gated by clear_now: the parent drops its clear on a hit, so set wins
   assign hit  = tick && cond && (step_cnt == limit);
   assign drop = tick && !cond && (step_cnt == 8'h00);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= 8'h00;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule // fmd_debounce
`default_nettype wire

// file: hw/fmd_detector.sv
// Purpose: Freefall/motion detection with its four byte registers
// Assumes: Register port and sample data come from logic on ref_clk
// Notes:   Accel inputs are signed, 8 g full scale, 1 LSB = 1/1024 g
//
// Overview of operation
// - Config bit 7 latches flags; source read clears active flag and all bits.
// - Config bit 6 picks freefall (AND) at 0 or motion (OR) at 1.
// - Config bits 5,4,3 enable Z, Y, X axes; cleared axis is excluded.
// - Latched: flags freeze once active flag sets, until source is read.
// - Unlatched: source flags follow the live detection state.
// - Freefall low holds when all enabled magnitudes are at or below threshold.
// - Motion holds when any enabled magnitude is strictly above threshold.
// - Source: active bit 7, bit 6 zero, Z/Y/X event and polarity pairs.
// - Polarity reads 0 for positive, 1 for negative acceleration.
// - Disabled axis reads zero event and polarity.
// - Active flag sets on the selected combination and feeds interrupt outputs.
// - Threshold register: debounce mode bit 7, 7-bit threshold, reset zero.
// - Threshold counts 0.063 g each, up to 8 g at any range.
// - Low-noise setting caps the reachable threshold at 4 g.
// - Debounce mode 1 clears the counter on a non-matching sample.
// - Debounce mode 0 decrements on non-matching samples, stopping at zero.
// - Counter increments on matching samples; count register resets to zero.
// - Event sets when counter reaches count value; counter never exceeds it.
// - Time step follows output rate; high resolution fixed 2.5 ms from 200 Hz.
// - Below 50 Hz: normal 20 ms, low-noise 80 ms, low-power 80/160 ms.
// - Motion, unlatched: source read clears nothing, counter untouched.
// - Latched: source read clears active flag and counter; full delay again.
// - While active flag is clear, flags show undebounced high-g per axis.
// - All three axis enables cleared disables detection.
`timescale 1ns/100ps
`default_nettype none
module fmd_detector
#(
   parameter int STEP_CYC = fmd_pkg::STEP_BASE_CYC
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata_ff,
   input  wire logic        sample_valid,
   input  wire logic [13:0] accel_x,
   input  wire logic [13:0] accel_y,
   input  wire logic [13:0] accel_z,
   input  wire logic [2:0]  output_sample_rate,
   input  wire logic [1:0]  oversample_mode,
   input  wire logic        low_noise_mode,
   input  wire logic        detect_interrupt_enable,
   input  wire logic        detect_interrupt_routing,
   output logic             event_active_flag_ff,
   output logic             irq_line1_ff,
   output logic             irq_line2_ff
);
   ////////////////////////////////////////////////////////////////////////////
   // Magnitude in threshold counts: 64 LSB of 1/1024 g is about 0.063 g
   function automatic logic [7:0] axis_mag(input logic [13:0] a);
      logic [13:0] m;
      m = a[13] ? (~a + 14'h0001) : a;
      return m[13:fmd_pkg::MAG_SHIFT];
   endfunction

   function automatic logic [7:0] step_mult(input logic [2:0] rate, input logic [1:0] osm);
      logic [7:0] r;
      r = fmd_pkg::MULT_16;
      case (rate)
         fmd_pkg::RATE_800: r = fmd_pkg::MULT_1;
         fmd_pkg::RATE_400: r = fmd_pkg::MULT_2;
         fmd_pkg::RATE_200: r = (osm == fmd_pkg::OSM_HIRES) ? fmd_pkg::MULT_2 : fmd_pkg::MULT_4;
         fmd_pkg::RATE_100: r = (osm == fmd_pkg::OSM_HIRES) ? fmd_pkg::MULT_2 : fmd_pkg::MULT_8;
         fmd_pkg::RATE_50:  r = (osm == fmd_pkg::OSM_HIRES) ? fmd_pkg::MULT_2 : fmd_pkg::MULT_16;
         default:
         begin
            case (osm)
               fmd_pkg::OSM_LOW_POWER_LOW_NOISE_MODE:  r = fmd_pkg::MULT_64;
               fmd_pkg::OSM_HIRES: r = fmd_pkg::MULT_2;
               fmd_pkg::OSM_LP:    r = (rate == fmd_pkg::RATE_12) ? fmd_pkg::MULT_64 : fmd_pkg::MULT_128;
               default:            r = fmd_pkg::MULT_16;
            endcase
         end
      endcase
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]  cfg_ff;
   logic [7:0]  ths_ff;
   logic [7:0]  count_ff;
   logic [5:0]  flags_ff;
   logic        cond_ff;
   logic [16:0] base_ff;
   logic [7:0]  mult_ff;
   logic [7:0]  dbc_cnt;
   logic        dbc_hit;
   logic        dbc_drop;

   wire         latch_en   = cfg_ff[fmd_pkg::CFG_LATCH_BIT];
   wire         or_sel     = cfg_ff[fmd_pkg::CFG_OR_BIT];
   wire  [2:0]  axis_en    = {cfg_ff[fmd_pkg::CFG_Z_BIT], cfg_ff[fmd_pkg::CFG_Y_BIT],
                              cfg_ff[fmd_pkg::CFG_X_BIT]};
   wire         dbc_mode   = ths_ff[fmd_pkg::THS_DBM_BIT];
   wire  [6:0]  trip_level = ths_ff[6:0];
   // Low-noise front end saturates near 4 g, so higher thresholds cannot trip
   wire  [6:0]  eff_level  = (low_noise_mode && trip_level > fmd_pkg::LOW_NOISE_CAP)
                             ? fmd_pkg::LOW_NOISE_CAP : trip_level;
   wire  [7:0]  level8     = {1'b0, eff_level};
   wire  [2:0]  axis_high  = {axis_mag(accel_z) > level8, axis_mag(accel_y) > level8,
                              axis_mag(accel_x) > level8};
   wire  [2:0]  axis_neg   = {accel_z[13], accel_y[13], accel_x[13]};
   wire  [2:0]  hit_en     = axis_high & axis_en;
   wire  [2:0]  low_ok     = ~axis_high | ~axis_en;
   wire         any_en     = |axis_en;
   wire         ff_cond    = any_en && (&low_ok);
   wire         mt_cond    = |hit_en;
   wire         nxt_cond   = or_sel ? mt_cond : ff_cond;
   wire  [5:0]  live_flags = {hit_en[2], hit_en[2] & axis_neg[2],
                              hit_en[1], hit_en[1] & axis_neg[1],
                              hit_en[0], hit_en[0] & axis_neg[0]};
   wire  [5:0]  flag_mask  = {{2{axis_en[2]}}, {2{axis_en[1]}}, {2{axis_en[0]}}};
   wire         src_read   = reg_rd && (reg_addr == fmd_pkg::ADDR_SRC);
   wire         latch_clr  = latch_en && src_read && !dbc_hit;
   wire         base_done  = base_ff == 17'(STEP_CYC - 1);
   wire         tick       = base_done && (mult_ff == 8'h01);
   ////////////////////////////////////////////////////////////////////////////
   logic        nxt_ea;
   logic [5:0]  nxt_flags;
   logic [7:0]  nxt_rdata;

   always_comb
   begin
      nxt_ea = event_active_flag_ff;
      if (dbc_hit)
      begin
         nxt_ea = 1'b1;
      end
      else if (latch_en)
      begin
         nxt_ea = src_read ? 1'b0 : event_active_flag_ff;
      end
      else if (dbc_drop)
      begin
         nxt_ea = 1'b0;
      end
   end

   always_comb
   begin
      nxt_flags = live_flags;
      if (latch_clr)
      begin
         nxt_flags = fmd_pkg::RST_FLAGS;
      end
      else if (latch_en && event_active_flag_ff)
      begin
         nxt_flags = flags_ff;
      end
   end

   always_comb
   begin
      case (reg_addr)
         fmd_pkg::ADDR_CFG: nxt_rdata = cfg_ff;
         fmd_pkg::ADDR_SRC: nxt_rdata = {event_active_flag_ff, 1'b0, flags_ff & flag_mask};
         fmd_pkg::ADDR_THS: nxt_rdata = ths_ff;
         fmd_pkg::ADDR_CNT: nxt_rdata = count_ff;
         default:           nxt_rdata = 8'h00;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_ff   <= fmd_pkg::RST_CFG;
         ths_ff   <= fmd_pkg::RST_THS;
         count_ff <= fmd_pkg::RST_CNT;
      end
      else if (reg_wr)
      begin
         if (reg_addr == fmd_pkg::ADDR_CFG)
         begin
            cfg_ff <= reg_wdata & fmd_pkg::CFG_WR_MASK;
         end
         if (reg_addr == fmd_pkg::ADDR_THS)
         begin
            ths_ff <= reg_wdata;
         end
         if (reg_addr == fmd_pkg::ADDR_CNT)
         begin
            count_ff <= reg_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata_ff <= 8'h00;
         event_active_flag_ff <= 1'b0;
         flags_ff     <= fmd_pkg::RST_FLAGS;
         cond_ff      <= 1'b0;
         irq_line1_ff <= 1'b0;
         irq_line2_ff <= 1'b0;
      end
      else
      begin
         if (reg_rd)
         begin
            reg_rdata_ff <= nxt_rdata;
         end
         event_active_flag_ff <= nxt_ea;
         if (sample_valid || latch_clr)
         begin
            flags_ff <= nxt_flags;
         end
         if (sample_valid)
         begin
            cond_ff <= nxt_cond;
         end
         irq_line1_ff <= event_active_flag_ff && detect_interrupt_enable && detect_interrupt_routing;
         irq_line2_ff <= event_active_flag_ff && detect_interrupt_enable && !detect_interrupt_routing;
      end
   end

   // Step timer: base 1.25 ms, repeated by the rate-dependent multiplier
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         base_ff <= 17'h00000;
         mult_ff <= 8'h01;
      end
      else if (base_done)
      begin
         base_ff <= 17'h00000;
         mult_ff <= (mult_ff <= 8'h01) ? step_mult(output_sample_rate, oversample_mode)
                                       : mult_ff - 8'h01;
      end
      else
      begin
         base_ff <= base_ff + 17'h00001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   fmd_debounce u_debounce
   (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .tick       (tick),
      .cond       (cond_ff),
      .clear_mode (dbc_mode),
      .clear_now  (latch_clr),
      .limit      (count_ff),
      .cnt_ff     (dbc_cnt),
      .hit        (dbc_hit),
      .drop       (dbc_drop)
   );
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   src_read_clear_a: assert property (
      latch_en && src_read && !dbc_hit |=> !event_active_flag_ff && flags_ff == 6'h00)
      else $error("latched source read did not clear flags");

   motion_or_a: assert property (
      sample_valid && or_sel && (|hit_en) |=> cond_ff)
      else $error("motion condition missed an enabled high axis");

   freeze_flags_a: assert property (
      latch_en && event_active_flag_ff && !src_read |=> $stable(flags_ff))
      else $error("latched flags changed before read");

   live_track_a: assert property (
      !latch_en && sample_valid |=> flags_ff == $past(live_flags))
      else $error("unlatched flags do not track live state");

   axis_zero_a: assert property (
      reg_rd && reg_addr == fmd_pkg::ADDR_SRC && !axis_en[2] |=> reg_rdata_ff[5:4] == 2'h0)
      else $error("disabled Z axis read nonzero");

   irq_route_a: assert property (
      event_active_flag_ff && detect_interrupt_enable && detect_interrupt_routing |=> irq_line1_ff && !irq_line2_ff)
      else $error("interrupt not routed to line 1");

   clear_mode_a: assert property (
      tick && !cond_ff && dbc_mode |=> dbc_cnt == 8'h00)
      else $error("debounce counter not cleared");

   dec_mode_a: assert property (
      tick && !cond_ff && !dbc_mode && !latch_clr && dbc_cnt != 8'h00 |=> dbc_cnt == $past(dbc_cnt) - 8'h01)
      else $error("debounce counter not decremented");

   count_cap_a: assert property (
      tick && !latch_clr |=> dbc_cnt <= $past(count_ff))
      else $error("debounce counter passed count value");

   read_keeps_a: assert property (
      !latch_en && src_read && event_active_flag_ff && !dbc_drop |=> event_active_flag_ff)
      else $error("unlatched read cleared active flag");

   cfg_write_a: assert property (
      reg_wr && reg_addr == fmd_pkg::ADDR_CFG |=> cfg_ff == ($past(reg_wdata) & fmd_pkg::CFG_WR_MASK))
      else $error("config write not masked to axis and mode bits");

   freefall_all_low_a: assert property (
      sample_valid && !or_sel && any_en && !(|hit_en) |=> cond_ff)
      else $error("freefall missed all enabled axes low");

   freefall_break_a: assert property (
      sample_valid && !or_sel && (|hit_en) |=> !cond_ff)
      else $error("freefall held with an enabled axis high");

   x_polarity_a: assert property (
      sample_valid && !latch_en && hit_en[0] && accel_x[13] |=> flags_ff[0])
      else $error("negative X event read positive");

   noise_cap_a: assert property (
      sample_valid && low_noise_mode && or_sel && axis_en[0] && axis_mag(accel_x) > {1'b0, fmd_pkg::LOW_NOISE_CAP}
      |=> cond_ff)
      else $error("low-noise cap not applied");

   ths_write_a: assert property (
      reg_wr && reg_addr == fmd_pkg::ADDR_THS |=> ths_ff == $past(reg_wdata))
      else $error("threshold write not stored");

   count_up_a: assert property (
      tick && cond_ff && !latch_clr && dbc_cnt < count_ff |=> dbc_cnt == $past(dbc_cnt) + 8'h01)
      else $error("debounce counter did not count a match");

   read_count_clear_a: assert property (
      latch_clr |=> dbc_cnt == 8'h00)
      else $error("latched source read left the counter running");

   undebounced_flags_a: assert property (
      sample_valid && !event_active_flag_ff && !latch_clr |=> flags_ff == $past(live_flags))
      else $error("flags not live while active flag clear");

   zero_count_a: assert property (
      tick && cond_ff && count_ff == 8'h00 |=> event_active_flag_ff)
      else $error("zero count did not fire on first match");
endmodule // fmd_detector
`default_nettype wire

// file: testbench/fmd_accel_src.sv
// Purpose: Sample source standing in for the sensor front end
// Assumes: Bench holds the wanted acceleration on ax, ay and az
// Notes:   Between samples the buses carry the inverse, so a stale read shows up
`timescale 1ns/100ps
`default_nettype none
module fmd_accel_src
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [13:0] ax,
   input  wire logic [13:0] ay,
   input  wire logic [13:0] az,
   output logic             sample_valid,
   output logic      [13:0] accel_x,
   output logic      [13:0] accel_y,
   output logic      [13:0] accel_z
);
   logic tog_ff;
   ////////////////////////////////////////////////////////////////////////////
   // One sample every second cycle
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tog_ff       <= 1'b0;
         sample_valid <= 1'b0;
         accel_x      <= 14'h0000;
         accel_y      <= 14'h0000;
         accel_z      <= 14'h0000;
      end
      else
      begin
         tog_ff       <= ~tog_ff;
         sample_valid <= tog_ff;
         accel_x      <= tog_ff ? ax : ~ax;
         accel_y      <= tog_ff ? ay : ~ay;
         accel_z      <= tog_ff ? az : ~az;
      end
   end
endmodule // fmd_accel_src
`default_nettype wire

// file: testbench/tb_freefall_motion_detector.sv
// Purpose: Self-checking bench for the freefall/motion detector
// Assumes: STEP_CYC shortened to 4, samples every second cycle
// Notes:   Waits of 40 cycles cover many debounce steps at 800 Hz
`timescale 1ns/100ps
`default_nettype none
module tb_freefall_motion_detector;
   logic             ref_clk;
   logic             rst_b;
   logic      [7:0]  reg_addr;
   logic      [7:0]  reg_wdata;
   logic             reg_wr;
   logic             reg_rd;
   logic      [13:0] ax;
   logic      [13:0] ay;
   logic      [13:0] az;
   logic      [2:0]  rate;
   logic      [1:0]  osm;
   logic             lnm;
   logic             ien;
   logic             iroute;
   wire logic        sample_valid;
   wire logic [13:0] accel_x;
   wire logic [13:0] accel_y;
   wire logic [13:0] accel_z;
   wire logic [7:0]  reg_rdata_ff;
   wire logic        ea;
   wire logic        irq1;
   wire logic        irq2;
   int               fail_count = 0;
   int               checks = 0;
   int               cyc = 0;

   fmd_accel_src u_src (.ref_clk(ref_clk), .rst_b(rst_b), .ax(ax), .ay(ay), .az(az),
      .sample_valid(sample_valid), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z));

   fmd_detector #(.STEP_CYC(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .sample_valid(sample_valid), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
      .output_sample_rate(rate), .oversample_mode(osm), .low_noise_mode(lnm),
      .detect_interrupt_enable(ien), .detect_interrupt_routing(iroute),
      .event_active_flag_ff(ea), .irq_line1_ff(irq1), .irq_line2_ff(irq2));
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic stop_test;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Hang guard; the sequence needs about 2700 cycles
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         stop_test;
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data is registered on the same edge that takes the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata_ff, exp);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic acc(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
      @(posedge ref_clk);
      ax <= x;
      ay <= y;
      az <= z;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ax = 14'h0000;
      ay = 14'h0000;
      az = 14'h0000;
      rate = 3'h0;
      osm = 2'h0;
      lnm = 1'b0;
      ien = 1'b1;
      iroute = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(fmd_pkg::ADDR_CFG, 8'h00);
      rd(fmd_pkg::ADDR_SRC, 8'h00);
      rd(fmd_pkg::ADDR_THS, 8'h00);
      rd(fmd_pkg::ADDR_CNT, 8'h00);
      rd(8'h20, 8'h00);
      wr(fmd_pkg::ADDR_CFG, 8'hFF);
      rd(fmd_pkg::ADDR_CFG, 8'hF8);
      wr(fmd_pkg::ADDR_SRC, 8'hFF);
      rd(fmd_pkg::ADDR_SRC, 8'h00);
      wr(fmd_pkg::ADDR_THS, 8'hFF);
      rd(fmd_pkg::ADDR_THS, 8'hFF);
      wr(fmd_pkg::ADDR_CNT, 8'hA5);
      rd(fmd_pkg::ADDR_CNT, 8'hA5);
      wr(fmd_pkg::ADDR_CNT, 8'h00);
      wr(fmd_pkg::ADDR_THS, 8'h10);
      // Motion, live flags, threshold 16 counts
      wr(fmd_pkg::ADDR_CFG, 8'h78);
      acc(14'h07D0, 14'h3830, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h8E);
      rd(fmd_pkg::ADDR_SRC, 8'h8E);
      chk({6'h00, irq2, irq1}, 8'h01);
      @(posedge ref_clk);
      iroute <= 1'b0;
      wt(3);
      chk({6'h00, irq2, irq1}, 8'h02);
      @(posedge ref_clk);
      ien <= 1'b0;
      wt(3);
      chk({6'h00, irq2, irq1}, 8'h00);
      @(posedge ref_clk);
      ien <= 1'b1;
      acc(14'h043F, 14'h0000, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h00);
      acc(14'h0440, 14'h0000, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h82);
      wr(fmd_pkg::ADDR_CFG, 8'h48);
      acc(14'h0000, 14'h3830, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h00);
      acc(14'h3830, 14'h0000, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h83);
      // Freefall: all magnitudes at the threshold count low
      wr(fmd_pkg::ADDR_CFG, 8'h38);
      acc(14'h0400, 14'h0400, 14'h0400);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h80);
      acc(14'h0400, 14'h0400, 14'h0440);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h20);
      wr(fmd_pkg::ADDR_CFG, 8'h00);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h00);
      // Latched motion: polarity must stay frozen until the read
      wr(fmd_pkg::ADDR_CFG, 8'hC8);
      acc(14'h07D0, 14'h0000, 14'h0000);
      wt(40);
      acc(14'h3830, 14'h0000, 14'h0000);
      wt(40);
      acc(14'h0000, 14'h0000, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h82);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h00);
      // Threshold scale and low-noise cap at 63 counts
      wr(fmd_pkg::ADDR_CFG, 8'h48);
      wr(fmd_pkg::ADDR_THS, 8'h7F);
      @(posedge ref_clk);
      lnm <= 1'b1;
      acc(14'h1000, 14'h0000, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h82);
      @(posedge ref_clk);
      lnm <= 1'b0;
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h00);
      acc(14'h2000, 14'h0000, 14'h0000);
      wt(40);
      rd(fmd_pkg::ADDR_SRC, 8'h83);
      // Debounce of three steps, clearing mode then decrementing mode
      wr(fmd_pkg::ADDR_THS, 8'h90);
      wr(fmd_pkg::ADDR_CNT, 8'h03);
      acc(14'h0000, 14'h0000, 14'h0000);
      wt(40);
      acc(14'h07D0, 14'h0000, 14'h0000);
      wt(6);
      chk({7'h00, ea}, 8'h00);
      wt(40);
      chk({7'h00, ea}, 8'h01);
      acc(14'h0000, 14'h0000, 14'h0000);
      wt(12);
      chk({7'h00, ea}, 8'h00);
      wr(fmd_pkg::ADDR_THS, 8'h10);
      acc(14'h07D0, 14'h0000, 14'h0000);
      wt(40);
      chk({7'h00, ea}, 8'h01);
      acc(14'h0000, 14'h0000, 14'h0000);
      wt(6);
      chk({7'h00, ea}, 8'h01);
      wt(16);
      chk({7'h00, ea}, 8'h00);
      // Slowest low-power step is 128 base steps
      wr(fmd_pkg::ADDR_CNT, 8'h02);
      @(posedge ref_clk);
      rate <= 3'h7;
      osm <= fmd_pkg::OSM_LP;
      acc(14'h07D0, 14'h0000, 14'h0000);
      wt(400);
      chk({7'h00, ea}, 8'h00);
      wt(800);
      chk({7'h00, ea}, 8'h01);
      // High resolution keeps 2 base steps at 50 Hz; normal would need 16
      @(posedge ref_clk);
      rate <= fmd_pkg::RATE_50;
      osm <= fmd_pkg::OSM_HIRES;
      acc(14'h0000, 14'h0000, 14'h0000);
      wt(600);
      chk({7'h00, ea}, 8'h00);
      acc(14'h07D0, 14'h0000, 14'h0000);
      wt(40);
      chk({7'h00, ea}, 8'h01);
      stop_test;
   end
endmodule // tb_freefall_motion_detector
`default_nettype wire
